/* md_host_model.sv */
// host-side model of the multidrop serial master
`timescale 1ns/1ps
`default_nettype none
module md_host_model (
    // resolved settings from the node
    input  wire logic [5:0] node_addr,
    input  wire logic       cfg_valid,
    // address the host polls
    input  wire logic [5:0] poll_addr,
    output logic            hit
);
    // node answers only once loaded and matching
    assign hit = cfg_valid && (node_addr == poll_addr);
endmodule
`default_nettype wire

/* node_cfg_defs.svh */
// constants for the multidrop node configuration selector
`ifndef NODE_CFG_DEFS_SVH
`define NODE_CFG_DEFS_SVH
`define ADDR_LSB       0
`define ADDR_MSB       5
`define RATE_LSB       6
`define RATE_MSB       7
`define ADDR_W         6
`define RATE_W         2
`define ADDR_FALLBACK  6'h00
`define RATE_FALLBACK  2'h0
`define RATE_CODE_9K6  2'h1
`define RATE_CODE_38K4 2'h2
`define RATE_CODE_115K 2'h3
`define SETTLE_CYCLES  4'h8
`define SYNC_CLEAR     8'h00
`define SETTLE_CLEAR   4'h0
`define SETTLE_STEP    4'h1
`endif

/* node_cfg_pkg.sv */
// types for the multidrop node configuration selector
package node_cfg_pkg;
    typedef enum logic [3:0] {
        ST_SETTLE = 4'b0001,
        ST_SAMPLE = 4'b0010,
        ST_RESOLVE = 4'b0100,
        ST_HOLD   = 4'b1000
    } load_state_e;
    typedef enum logic [3:0] {
        RATE_STORED = 4'b0001,
        RATE_9K6    = 4'b0010,
        RATE_38K4   = 4'b0100,
        RATE_115K   = 4'b1000
    } rate_sel_e;
endpackage

/* serial_node_config_select.sv */
// multidrop node address and bit-rate selection from configuration switches
`timescale 1ns/1ps
`default_nettype none
`include "node_cfg_defs.svh"

// Notes on behaviour
// - switches one to six form node address, switch one lsb, closed is one
// - switches seven and eight form rate code, switch seven lsb
// - switches steer only multidrop port, never the point-to-point port
// - zero address or zero rate from switches uses stored value, independently
// - rate code 1,2,3 select 9.6, 38.4, 115.2 kbps; 0 selects stored
module serial_node_config_select
    import node_cfg_pkg::*;
(
    // clock, reset, enable
    input  wire logic                sys_clk,
    input  wire logic                reset_n,
    input  wire logic                clk_en,
    // switches, closed reads high; switch n at bit n-1
    input  wire logic [7:0]          sw_closed,
    // values held in non-volatile memory
    input  wire logic [`ADDR_W-1:0]  stored_addr,
    input  wire logic [`RATE_W-1:0]  stored_rate,
    // resolved multidrop settings
    output logic      [`ADDR_W-1:0]  node_addr,
    output logic      [`RATE_W-1:0]  rate_code,
    output logic      [3:0]          rate_sel,
    output logic                     cfg_valid
);
    logic [7:0]          sync1_r;
    logic [7:0]          sync2_r;
    logic [7:0]          sync3_r;
    logic [3:0]          settle_r;
    logic [7:0]          sw_r;
    load_state_e         state_r;
    logic [`ADDR_W-1:0]  sw_addr;
    logic [`RATE_W-1:0]  sw_rate;
    logic [`RATE_W-1:0]  eff_rate;

    // switches are asynchronous pins: three stages
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            sync1_r <= `SYNC_CLEAR;
            sync2_r <= `SYNC_CLEAR;
            sync3_r <= `SYNC_CLEAR;
        end else if (clk_en) begin
            sync1_r <= sw_closed;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // wait for the sync chain to fill and bits to agree
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            settle_r <= `SETTLE_CLEAR;
        end else if (clk_en && state_r == ST_SETTLE) begin
            // a bouncing switch restarts the wait
            if (sync2_r != sync3_r)
                settle_r <= `SETTLE_CLEAR;
            else if (settle_r != `SETTLE_CYCLES)
                settle_r <= settle_r + `SETTLE_STEP;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state_r <= ST_SETTLE;
        end else if (clk_en) begin
            unique case (state_r)
                ST_SETTLE: begin
                    if (settle_r == `SETTLE_CYCLES && sync2_r == sync3_r)
                        state_r <= ST_SAMPLE;
                end
                ST_SAMPLE:  state_r <= ST_RESOLVE;
                ST_RESOLVE: state_r <= ST_HOLD;
                ST_HOLD:    state_r <= ST_HOLD;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n)
            sw_r <= `SYNC_CLEAR;
        else if (clk_en && state_r == ST_SAMPLE)
            sw_r <= sync3_r;
    end

    assign sw_addr = sw_r[`ADDR_MSB:`ADDR_LSB];
    assign sw_rate = sw_r[`RATE_MSB:`RATE_LSB];
    assign eff_rate = (sw_rate == `RATE_FALLBACK) ? stored_rate : sw_rate;

    // outputs feed the multidrop port only; no point-to-point output exists
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            node_addr <= `ADDR_FALLBACK;
            rate_code <= `RATE_FALLBACK;
            rate_sel  <= RATE_STORED;
            cfg_valid <= 1'b0;
        end else if (clk_en && state_r == ST_RESOLVE) begin
            node_addr <= (sw_addr == `ADDR_FALLBACK) ? stored_addr : sw_addr;
            rate_code <= eff_rate;
            unique case (sw_rate)
                `RATE_CODE_9K6:  rate_sel <= RATE_9K6;
                `RATE_CODE_38K4: rate_sel <= RATE_38K4;
                `RATE_CODE_115K: rate_sel <= RATE_115K;
                `RATE_FALLBACK:  rate_sel <= RATE_STORED;
            endcase
            cfg_valid <= 1'b1;
        end
    end

    // assertions
    property p_addr_map;
        @(posedge sys_clk) disable iff (!reset_n)
        (clk_en && state_r == ST_RESOLVE && sw_addr != `ADDR_FALLBACK)
            |=> node_addr == $past(sw_r[`ADDR_MSB:`ADDR_LSB]);
    endproperty
    a_addr_map: assert property (p_addr_map) else $error("address not from switches");

    property p_rate_map;
        @(posedge sys_clk) disable iff (!reset_n)
        (clk_en && state_r == ST_RESOLVE && sw_rate != `RATE_FALLBACK)
            |=> rate_code == $past(sw_r[`RATE_MSB:`RATE_LSB]);
    endproperty
    a_rate_map: assert property (p_rate_map) else $error("rate not from switches");

    property p_addr_fallback;
        @(posedge sys_clk) disable iff (!reset_n)
        (clk_en && state_r == ST_RESOLVE && sw_addr == `ADDR_FALLBACK)
            |=> node_addr == $past(stored_addr);
    endproperty
    a_addr_fallback: assert property (p_addr_fallback) else $error("address fallback wrong");

    property p_rate_fallback;
        @(posedge sys_clk) disable iff (!reset_n)
        (clk_en && state_r == ST_RESOLVE && sw_rate == `RATE_FALLBACK)
            |=> rate_code == $past(stored_rate) && rate_sel == RATE_STORED;
    endproperty
    a_rate_fallback: assert property (p_rate_fallback) else $error("rate fallback wrong");

    property p_rate_115k;
        @(posedge sys_clk) disable iff (!reset_n)
        (clk_en && state_r == ST_RESOLVE && sw_rate == `RATE_CODE_115K)
            |=> rate_sel == RATE_115K;
    endproperty
    a_rate_115k: assert property (p_rate_115k) else $error("rate 3 not 115.2k");

    property p_rate_9k6;
        @(posedge sys_clk) disable iff (!reset_n)
        (clk_en && state_r == ST_RESOLVE && sw_rate == `RATE_CODE_9K6)
            |=> rate_sel == RATE_9K6;
    endproperty
    a_rate_9k6: assert property (p_rate_9k6) else $error("rate 1 not 9.6k");

    sequence s_loaded;
        cfg_valid ##1 cfg_valid;
    endsequence
    property p_hold;
        @(posedge sys_clk) disable iff (!reset_n)
        s_loaded |-> $stable(node_addr) && $stable(rate_code) && $stable(rate_sel);
    endproperty
    a_hold: assert property (p_hold) else $error("settings changed after load");

    property p_valid_sticky;
        @(posedge sys_clk) disable iff (!reset_n)
        cfg_valid |=> cfg_valid && state_r == ST_HOLD;
    endproperty
    a_valid_sticky: assert property (p_valid_sticky) else $error("valid dropped");

    property p_one_sample;
        @(posedge sys_clk) disable iff (!reset_n)
        (state_r == ST_HOLD) |=> $stable(sw_r);
    endproperty
    a_one_sample: assert property (p_one_sample) else $error("switches resampled");

    property p_rate_38k4;
        @(posedge sys_clk) disable iff (!reset_n)
        (clk_en && state_r == ST_RESOLVE && sw_rate == `RATE_CODE_38K4)
            |=> rate_sel == RATE_38K4;
    endproperty
    a_rate_38k4: assert property (p_rate_38k4) else $error("rate 2 not 38.4k");

    sequence s_sampling;
        clk_en && state_r == ST_SAMPLE;
    endsequence
    property p_sample_then_resolve;
        @(posedge sys_clk) disable iff (!reset_n)
        s_sampling |=> state_r == ST_RESOLVE;
    endproperty
    a_sample_then_resolve: assert property (p_sample_then_resolve) else $error("no resolve step");

    property p_resolve_then_hold;
        @(posedge sys_clk) disable iff (!reset_n)
        (clk_en && state_r == ST_RESOLVE) |=> state_r == ST_HOLD && cfg_valid;
    endproperty
    a_resolve_then_hold: assert property (p_resolve_then_hold) else $error("load not completed");

    property p_valid_rise;
        @(posedge sys_clk) disable iff (!reset_n)
        $rose(cfg_valid) |-> $past(state_r) == ST_RESOLVE;
    endproperty
    a_valid_rise: assert property (p_valid_rise) else $error("valid rose outside resolve");

    property p_sample_entry;
        @(posedge sys_clk) disable iff (!reset_n)
        (clk_en && state_r == ST_SETTLE && settle_r == `SETTLE_CYCLES
            && sync2_r == sync3_r)
            |=> state_r == ST_SAMPLE;
    endproperty
    a_sample_entry: assert property (p_sample_entry) else $error("settled but not sampled");

    property p_settle_bound;
        @(posedge sys_clk) disable iff (!reset_n)
        settle_r <= `SETTLE_CYCLES;
    endproperty
    a_settle_bound: assert property (p_settle_bound) else $error("settle count overrun");

    // enable low freezes all state
    property p_freeze;
        @(posedge sys_clk) disable iff (!reset_n)
        !clk_en |=> $stable(state_r) && $stable(settle_r) && $stable(sw_r)
            && $stable(sync3_r) && $stable(node_addr) && $stable(rate_sel)
            && $stable(cfg_valid);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while disabled");
endmodule
`default_nettype wire

/* serial_node_config_select_tb.sv */
// self-checking bench for the multidrop configuration selector
`timescale 1ns/1ps
`default_nettype none
module serial_node_config_select_tb;
    logic       sys_clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       clk_en = 1'b1;
    logic [7:0] sw_closed = 8'h00;
    logic [5:0] stored_addr = 6'h00;
    logic [1:0] stored_rate = 2'h0;
    logic [5:0] poll_addr = 6'h00;
    logic [5:0] node_addr;
    logic [1:0] rate_code;
    logic [3:0] rate_sel;
    logic       cfg_valid;
    logic       hit;
    int         mismatches = 0;
    int         checked = 0;
    always #25 sys_clk = ~sys_clk;
    serial_node_config_select dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
        .sw_closed(sw_closed), .stored_addr(stored_addr), .stored_rate(stored_rate),
        .node_addr(node_addr), .rate_code(rate_code), .rate_sel(rate_sel),
        .cfg_valid(cfg_valid));
    md_host_model host_u (.node_addr(node_addr), .cfg_valid(cfg_valid),
        .poll_addr(poll_addr), .hit(hit));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    function automatic logic [15:0] outs();
        return {3'h0, cfg_valid, node_addr, rate_code, rate_sel};
    endfunction
    function automatic logic [15:0] want(input logic [7:0] sw, input logic [5:0] sa,
                                         input logic [1:0] sr);
        logic [5:0] a;
        logic [1:0] c;
        a = (sw[5:0] != 6'h00) ? sw[5:0] : sa;
        c = (sw[7:6] != 2'h0) ? sw[7:6] : sr;
        return {4'h1, a, c, 4'h1 << sw[7:6]};
    endfunction
    // reset with switches set, then bounded wait for the load
    task automatic load(input logic [7:0] sw, input logic [5:0] sa, input logic [1:0] sr);
        @(negedge sys_clk);
        reset_n = 1'b0;
        sw_closed = sw;
        stored_addr = sa;
        stored_rate = sr;
        repeat (6) @(negedge sys_clk);
        reset_n = 1'b1;
        for (int i = 0; i < 60 && cfg_valid !== 1'b1; i++) @(negedge sys_clk);
        if (cfg_valid !== 1'b1) begin
            mismatches++;
            end_sim();
        end
    endtask
    task automatic s_addr_bits();
        for (int i = 0; i < 6; i++) begin
            load(8'h40 | (8'h01 << i), 6'h15, 2'h2);
            check(outs(), want(8'h40 | (8'h01 << i), 6'h15, 2'h2));
        end
    endtask
    task automatic s_rate_codes();
        for (int c = 0; c < 4; c++) begin
            load({c[1:0], 6'h3f}, 6'h0a, 2'h3);
            check(outs(), want({c[1:0], 6'h3f}, 6'h0a, 2'h3));
        end
    endtask
    task automatic s_fallback();
        load(8'h00, 6'h2a, 2'h1);
        check(outs(), {4'h1, 6'h2a, 2'h1, 4'h1});
        load(8'hc0, 6'h33, 2'h2);
        check(outs(), {4'h1, 6'h33, 2'h3, 4'h8});
    endtask
    // switch and stored changes after load must not leak through
    task automatic s_hold();
        load(8'h9e, 6'h11, 2'h1);
        sw_closed = 8'h41;
        stored_addr = 6'h05;
        stored_rate = 2'h2;
        repeat (30) @(negedge sys_clk);
        check(outs(), {4'h1, 6'h1e, 2'h2, 4'h4});
        poll_addr = 6'h1e;
        @(negedge sys_clk);
        check({15'h0, hit}, 16'h0001);
        poll_addr = 6'h01;
        @(negedge sys_clk);
        check({15'h0, hit}, 16'h0000);
    endtask
    // enable held low after release: nothing may load until it rises
    task automatic s_freeze();
        @(negedge sys_clk);
        clk_en = 1'b0;
        reset_n = 1'b0;
        sw_closed = 8'h5b;
        stored_addr = 6'h21;
        stored_rate = 2'h3;
        repeat (6) @(negedge sys_clk);
        reset_n = 1'b1;
        repeat (40) @(negedge sys_clk);
        check(outs(), 16'h0001);
        clk_en = 1'b1;
        for (int i = 0; i < 60 && cfg_valid !== 1'b1; i++) @(negedge sys_clk);
        if (cfg_valid !== 1'b1) begin
            mismatches++;
            end_sim();
        end
        check(outs(), want(8'h5b, 6'h21, 2'h3));
    endtask
    initial begin
        s_addr_bits();
        s_rate_codes();
        s_fallback();
        s_freeze();
        s_hold();
        end_sim();
    end
endmodule
`default_nettype wire
